// ### hdl/spsc_cfg.sv
`default_nettype none
// Configuration store, reset to defaults by shutdown, kept through standby
module spsc_cfg (
  input  wire logic        clk,          // System clock
  input  wire logic        rst_n,        // Shutdown-qualified reset
  input  wire logic        wr_en,        // Config write strobe
  input  wire logic [10:0] gpio_oe_w,    // GPIO enable value
  input  wire logic [10:0] gpio_do_w,    // GPIO level value
  input  wire logic        gpio_mode_w,  // GPIO mode value
  input  wire logic [5:0]  lane_idle_w,  // Lane idle value
  input  wire logic [3:0]  misc_oe_w,    // Misc enable value
  input  wire logic        pwm_oe_w,     // PWM enable value
  input  wire logic        sync_out_w,   // Sync direction value
  output logic      [10:0] gpio_oe,      // Stored GPIO enables
  output logic      [10:0] gpio_do,      // Stored GPIO levels
  output logic             gpio_mode,    // Stored GPIO mode
  output logic      [5:0]  lane_idle,    // Stored lane idle
  output logic      [3:0]  misc_oe,      // Stored misc enables
  output logic             pwm_oe,       // Stored PWM enable
  output logic             sync_out      // Stored sync direction
);
  logic [34:0] cfg_q;                    // Packed config register
  logic [34:0] cfg_d;                    // Next config
  // Load on write, hold otherwise
  always_comb begin
    cfg_d = cfg_q;
    if (wr_en) begin
      cfg_d = {gpio_oe_w, gpio_do_w, gpio_mode_w, lane_idle_w,
               misc_oe_w, pwm_oe_w, sync_out_w};
    end
  end
  // Defaults on shutdown reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg_q <= {spsc_pkg::GPIO_OE_RST, spsc_pkg::GPIO_DO_RST,
                spsc_pkg::GPIO_MODE_RST, spsc_pkg::LANE_IDLE_RST,
                spsc_pkg::MISC_OE_RST, spsc_pkg::PWM_OE_RST,
                spsc_pkg::SYNC_OUT_RST};
    end else begin
      cfg_q <= cfg_d;
    end
  end
  assign {gpio_oe, gpio_do, gpio_mode, lane_idle,
          misc_oe, pwm_oe, sync_out} = cfg_q;
endmodule
`default_nettype wire

// ### hdl/spsc_top.sv
`default_nettype none
// Pad state and function control for the sensor's digital pads
module spsc_top (
  input  wire logic        SYS_CLK,          // 250 MHz clock
  input  wire logic        RESET_N,          // Sync reset, active low
  input  wire logic        SHUTDOWN_RESET_N, // Shutdown pad, active low
  input  wire logic        TEST_MODE_IN,     // Test pad, pulled down
  input  wire logic        CFG_WR,           // Config write strobe
  input  wire logic [10:0] CFG_GPIO_OE,      // GPIO enables
  input  wire logic [10:0] CFG_GPIO_DO,      // GPIO levels
  input  wire logic        CFG_GPIO_MODE,    // 1 GPIO, 0 video data
  input  wire logic [5:0]  CFG_LANE_IDLE,    // Lane idle levels
  input  wire logic [3:0]  CFG_MISC_OE,      // pclk/lv/strobe/sync enables
  input  wire logic        CFG_PWM_OE,       // PWM enable
  input  wire logic        CFG_SYNC_OUT,     // 1 vsync out, 0 frame in
  input  wire logic        STREAM_EN,        // Mode-select low bit
  input  wire logic [9:0]  VIDEO_DATA,       // Parallel video data
  input  wire logic        PIX_CLK,          // Internal pixel clock
  input  wire logic        LINE_VALID,       // Internal line valid
  input  wire logic        STROBE_IN,        // Internal strobe
  input  wire logic        VSYNC_IN,         // Internal vertical sync
  input  wire logic        PWM_IN,           // Internal PWM
  input  wire logic        TEST_OUT_IN,      // Internal test result
  input  wire logic [5:0]  LANE_DATA,        // Internal lane drive
  input  wire logic        SDA_LOW,          // Control data pulls low
  input  wire logic        FRAME_SYNC_PAD_I, // Sync pad level in
  output logic             FRAME_SYNC_PAD_O, // Sync pad level out
  output logic             FRAME_SYNC_PAD_OE,// Sync pad drive enable
  output logic      [10:0] GPIO_PAD_O,       // Video/GPIO pad out
  output logic      [10:0] GPIO_PAD_OE,      // Video/GPIO pad enable
  output logic             PIX_CLK_O,        // Pixel clock pad out
  output logic             PIX_CLK_OE,       // Pixel clock enable
  output logic             LINE_VALID_OUT,   // Line valid pad out
  output logic             LINE_VALID_OE,    // Line valid enable
  output logic             STROBE_O,         // Strobe pad out
  output logic             STROBE_OE,        // Strobe enable
  output logic             PWM_O,            // PWM pad out
  output logic             PWM_OE,           // PWM enable
  output logic             TEST_MODE_OUT,    // Test output pad
  output logic             TEST_MODE_OE,     // Test output enable
  output logic      [5:0]  LANE_O,           // Lane pad levels
  output logic      [5:0]  LANE_OE,          // Lane pad enables
  output logic             SDA_OE,           // Open-drain pull enable
  output logic             FRAME_SYNC_IN,    // Captured frame sync
  output logic             TEST_ACTIVE,      // Test behaviour active
  output logic             ACTIVE            // Streaming, not standby
);
  logic         cfg_rst_n;                   // Reset or shutdown
  logic [10:0]  gpio_oe;                     // Stored enables
  logic [10:0]  gpio_do;                     // Stored levels
  logic         gpio_mode;                   // Stored mode
  logic [5:0]   lane_idle;                   // Stored idle levels
  logic [3:0]   misc_oe;                     // Stored misc enables
  logic         pwm_oe;                      // Stored PWM enable
  logic         sync_out;                    // Stored direction
  spsc_pkg::spsc_state_t st_q, st_d;         // Power state
  logic [46:0]  pad_q, pad_d;                // Registered pad outputs
  logic         fsi_q, fsi_d;                // Captured frame sync
  logic         test_q, test_d;              // Test behaviour flag
  logic         act_q, act_d;                // Streaming flag

  // Shutdown acts as a hardware reset of the configuration
  assign cfg_rst_n = RESET_N & SHUTDOWN_RESET_N;

  spsc_cfg u_cfg (
    .clk        (SYS_CLK),
    .rst_n      (cfg_rst_n),
    .wr_en      (CFG_WR),
    .gpio_oe_w  (CFG_GPIO_OE),
    .gpio_do_w  (CFG_GPIO_DO),
    .gpio_mode_w(CFG_GPIO_MODE),
    .lane_idle_w(CFG_LANE_IDLE),
    .misc_oe_w  (CFG_MISC_OE),
    .pwm_oe_w   (CFG_PWM_OE),
    .sync_out_w (CFG_SYNC_OUT),
    .gpio_oe    (gpio_oe),
    .gpio_do    (gpio_do),
    .gpio_mode  (gpio_mode),
    .lane_idle  (lane_idle),
    .misc_oe    (misc_oe),
    .pwm_oe     (pwm_oe),
    .sync_out   (sync_out)
  );

  // Power state: shutdown, standby, streaming
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      spsc_pkg::SPSC_SHUTDOWN: begin
        st_d = spsc_pkg::SPSC_STANDBY;
      end
      spsc_pkg::SPSC_STANDBY: begin
        if (STREAM_EN) begin
          st_d = spsc_pkg::SPSC_STREAM;
        end
      end
      spsc_pkg::SPSC_STREAM: begin
        if (!STREAM_EN) begin
          st_d = spsc_pkg::SPSC_STANDBY;
        end
      end
      default: st_d = spsc_pkg::SPSC_SHUTDOWN;
    endcase
    if (!SHUTDOWN_RESET_N) begin
      st_d = spsc_pkg::SPSC_SHUTDOWN;
    end
  end
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      st_q <= spsc_pkg::SPSC_SHUTDOWN;
    end else begin
      st_q <= st_d;
    end
  end

  // Pad levels and enables from state and configuration; the next power
  // state is used so pads follow a mode change on the same edge as ACTIVE
  always_comb begin
    logic        run;                        // Streaming after this edge
    logic        up;                         // Shutdown pad released
    logic [10:0] go;                         // Video/GPIO pad levels
    logic [5:0]  lo;                         // Lane pad levels
    logic [46:0] p;                          // Packed pad image
    run = (st_d == spsc_pkg::SPSC_STREAM);
    up  = SHUTDOWN_RESET_N;
    go  = gpio_mode ? gpio_do : {gpio_do[10], VIDEO_DATA};
    lo  = run ? LANE_DATA : lane_idle;
    p   = '0;
    // Video data must not leak onto the pads while idle
    if (!gpio_mode && !run) begin
      go[9:0] = 10'h000;                     // Video forced low in standby
    end
    // Every pad floats until the shutdown pad is released
    if (up) begin
      p = {go, gpio_oe,
           PIX_CLK & run, misc_oe[spsc_pkg::MISC_PCLK],
           LINE_VALID & run, misc_oe[spsc_pkg::MISC_LV],
           STROBE_IN & run, misc_oe[spsc_pkg::MISC_STRB],
           PWM_IN, pwm_oe,
           TEST_OUT_IN & TEST_MODE_IN, 1'h1,
           lo, 6'h3f,
           SDA_LOW,
           VSYNC_IN & run,
           misc_oe[spsc_pkg::MISC_SYNC] & sync_out};
    end
    pad_d  = p;
    fsi_d  = up & ~sync_out & FRAME_SYNC_PAD_I;
    test_d = up & TEST_MODE_IN;
    act_d  = run;
    // Chip reset clears every pad flop
    if (!RESET_N) begin
      pad_d  = '0;
      fsi_d  = 1'h0;
      test_d = 1'h0;
      act_d  = 1'h0;
    end
  end
  // Pad flops: every output of the block comes straight from here
  always_ff @(posedge SYS_CLK) begin
    pad_q  <= pad_d;
    fsi_q  <= fsi_d;
    test_q <= test_d;
    act_q  <= act_d;
  end

  // Unpack the registered pad image onto the pins; outputs are plain
  // copies of flops so the pads never glitch on a config change
  assign {GPIO_PAD_O, GPIO_PAD_OE, PIX_CLK_O, PIX_CLK_OE,
          LINE_VALID_OUT, LINE_VALID_OE, STROBE_O, STROBE_OE,
          PWM_O, PWM_OE, TEST_MODE_OUT, TEST_MODE_OE,
          LANE_O, LANE_OE, SDA_OE, FRAME_SYNC_PAD_O,
          FRAME_SYNC_PAD_OE} = pad_q;
  assign FRAME_SYNC_IN = fsi_q;
  assign TEST_ACTIVE   = test_q;
  assign ACTIVE        = act_q;

  // Checks on the pads and stored config, sampled one edge after their cause
  a_shut_float: assert property (
    @(posedge SYS_CLK) disable iff (!RESET_N)
    !SHUTDOWN_RESET_N |=> (LANE_OE == 6'h00) && (GPIO_PAD_OE == 11'h000)
      && !SDA_OE && !PWM_OE && !TEST_MODE_OE)
    else $error("pad driven during shutdown");
  a_lane_idle: assert property (
    @(posedge SYS_CLK) disable iff (!RESET_N)
    SHUTDOWN_RESET_N && !STREAM_EN |=> LANE_O == $past(lane_idle))
    else $error("lane idle level wrong");
  a_gpio_def: assert property (
    @(posedge SYS_CLK) disable iff (!RESET_N)
    $rose(SHUTDOWN_RESET_N) |=> GPIO_PAD_OE == 11'h000 && !PIX_CLK_OE
      && !STROBE_OE && !FRAME_SYNC_PAD_OE)
    else $error("pad not floating after release");
  a_pwm_drive: assert property (
    @(posedge SYS_CLK) disable iff (!RESET_N)
    $rose(SHUTDOWN_RESET_N) |=> PWM_OE && TEST_MODE_OE)
    else $error("pwm or test pad not driving");
  a_test_low: assert property (
    @(posedge SYS_CLK) disable iff (!RESET_N)
    !TEST_MODE_IN |=> !TEST_MODE_OUT)
    else $error("test output without test mode");
  a_test_flag: assert property (
    @(posedge SYS_CLK) disable iff (!RESET_N)
    !TEST_MODE_IN |=> !TEST_ACTIVE)
    else $error("test behaviour without test input");
  a_sync_dir: assert property (
    @(posedge SYS_CLK) disable iff (!RESET_N)
    sync_out |=> !FRAME_SYNC_IN)
    else $error("sync input captured in output mode");
  a_standby_hold: assert property (
    @(posedge SYS_CLK) disable iff (!RESET_N)
    SHUTDOWN_RESET_N && !STREAM_EN |=> !ACTIVE && !PIX_CLK_O)
    else $error("activity in standby");
  a_cfg_default: assert property (
    @(posedge SYS_CLK) disable iff (!RESET_N)
    !SHUTDOWN_RESET_N |=> lane_idle == spsc_pkg::LANE_IDLE_RST
      && gpio_oe == spsc_pkg::GPIO_OE_RST && pwm_oe)
    else $error("config not defaulted");

  // Main scenarios worth seeing at least once
  c_stream: cover property (@(posedge SYS_CLK) $rose(ACTIVE));
  c_vsync: cover property (@(posedge SYS_CLK) FRAME_SYNC_PAD_OE);
  c_gpio: cover property (@(posedge SYS_CLK) |GPIO_PAD_OE && gpio_mode);
  c_test: cover property (@(posedge SYS_CLK) TEST_ACTIVE);
  c_wake: cover property (@(posedge SYS_CLK) $rose(SHUTDOWN_RESET_N));
endmodule
`default_nettype wire

// ### inc/spsc_pkg.sv
// What this block does
// - Shutdown low resets and powers down device
// - Serial video lanes idle high, configurable level
// - Video, GPIO, clock, sync pads default high-z
// - PWM and test outputs drive in standby
// - Test mode only when test input high
// - Sync pad: frame input or vsync output
// - Standby bit stops activity except PWM and test outputs, keeps config
// - Shutdown reset returns config to defaults
`default_nettype none
package spsc_pkg;
  localparam int          GPIO_W      = 11;        // D0..D9 plus general_io_ten
  localparam int          LANE_N      = 6;         // Lane pads: d0p d0n d1p d1n cp cn
  localparam logic [10:0] GPIO_OE_RST = 11'h000;   // Video/GPIO pads float
  localparam logic [10:0] GPIO_DO_RST = 11'h000;   // GPIO drive levels
  localparam logic        GPIO_MODE_RST = 1'h0;    // 0 video data, 1 GPIO
  localparam logic [5:0]  LANE_IDLE_RST = 6'h3f;   // Lanes idle high
  localparam logic [3:0]  MISC_OE_RST = 4'h0;      // pclk, lv, strobe, sync
  localparam logic        PWM_OE_RST  = 1'h1;      // PWM pad drives
  localparam logic        SYNC_OUT_RST = 1'h0;     // 0 frame-sync input
  localparam logic        STREAM_RST  = 1'h0;      // Standby after reset
  localparam int          MISC_PCLK   = 0;         // Misc enable bit positions
  localparam int          MISC_LV     = 1;
  localparam int          MISC_STRB   = 2;
  localparam int          MISC_SYNC   = 3;
  typedef enum logic [1:0] {
    SPSC_SHUTDOWN,                                 // Shutdown held low
    SPSC_STANDBY,                                  // Software standby
    SPSC_STREAM                                    // Active operation
  } spsc_state_t;
endpackage
`default_nettype wire

// ### verification/spsc_host.sv
`default_nettype none
// Host side: drives the shutdown pad and the mode-select low bit
module spsc_host (
  input  wire logic clk,       // System clock
  output var  logic shut_n,    // Shutdown pad drive, active low
  output var  logic stream_en  // Mode-select low bit
);
  timeunit 1ns;
  timeprecision 1ps;
  // Power up with the sensor held in shutdown
  initial begin
    shut_n = 1'h0;
    stream_en = 1'h0;
  end
  // Change the shutdown pad just after an edge
  task automatic set_shutdown(input logic lvl);
    @(posedge clk);
    #1 shut_n = lvl;
  endtask
  // Write the mode-select bit: 1 streams, 0 standby
  task automatic set_stream(input logic en);
    @(posedge clk);
    #1 stream_en = en;
  endtask
endmodule
`default_nettype wire

// ### verification/spsc_tb_top.sv
`default_nettype none
module spsc_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic SYS_CLK, RESET_N, SHUTDOWN_RESET_N, TEST_MODE_IN, CFG_WR;
  logic [10:0] CFG_GPIO_OE, CFG_GPIO_DO, GPIO_PAD_O, GPIO_PAD_OE;
  logic CFG_GPIO_MODE, CFG_PWM_OE, CFG_SYNC_OUT, STREAM_EN, PIX_CLK;
  logic [5:0] CFG_LANE_IDLE, LANE_DATA, LANE_O, LANE_OE;
  logic [3:0] CFG_MISC_OE;
  logic [9:0] VIDEO_DATA;
  logic LINE_VALID, STROBE_IN, VSYNC_IN, PWM_IN, TEST_OUT_IN, SDA_LOW;
  logic FRAME_SYNC_PAD_I, FRAME_SYNC_PAD_O, FRAME_SYNC_PAD_OE, PIX_CLK_O;
  logic PIX_CLK_OE, LINE_VALID_OUT, LINE_VALID_OE, STROBE_O, STROBE_OE;
  logic PWM_O, PWM_OE, TEST_MODE_OUT, TEST_MODE_OE, SDA_OE, FRAME_SYNC_IN;
  logic TEST_ACTIVE, ACTIVE;
  int err_count, n_checks;
  // Host model owns the shutdown pad and the mode bit
  spsc_host host (.clk(SYS_CLK), .shut_n(SHUTDOWN_RESET_N),
                  .stream_en(STREAM_EN));
  spsc_top dut (.*);
  // 4 ns clock
  always #2 SYS_CLK = ~SYS_CLK;
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Wait edges, then step off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge SYS_CLK);
    #1;
  endtask
  // One config write strobe
  task automatic cfg(input logic [10:0] oe, dout, input logic md,
                     input logic [5:0] idle, input logic [3:0] misc,
                     input logic pwm, input logic so);
    {CFG_GPIO_OE, CFG_GPIO_DO, CFG_GPIO_MODE} = {oe, dout, md};
    {CFG_LANE_IDLE, CFG_MISC_OE, CFG_PWM_OE, CFG_SYNC_OUT} =
      {idle, misc, pwm, so};
    CFG_WR = 1'h1;
    tick(1);
    CFG_WR = 1'h0;
  endtask
  // Shutdown low floats every pad
  task automatic t_shutdown();
    tick(2);
    chk({GPIO_PAD_OE, LANE_OE, PIX_CLK_OE, LINE_VALID_OE, STROBE_OE,
         FRAME_SYNC_PAD_OE, PWM_OE, TEST_MODE_OE, SDA_OE}, 32'h0);
    chk(ACTIVE, 32'h0);
    $display("done shutdown");
  endtask
  // Release: lanes high, PWM, test out and SDA pull drive, rest float
  task automatic t_release();
    host.set_shutdown(1'h1);
    tick(2);
    chk({LANE_OE, LANE_O}, 32'hfff);
    chk({PWM_OE, TEST_MODE_OE}, 32'h3);
    chk({GPIO_PAD_OE, PIX_CLK_OE, LINE_VALID_OE, STROBE_OE,
         FRAME_SYNC_PAD_OE}, 32'h0);
    chk(SDA_OE, 32'h1);
    chk(PWM_O, 32'h1);
    chk(TEST_MODE_OUT, 32'h0);
    chk({PIX_CLK_O, LINE_VALID_OUT, STROBE_O}, 32'h0);
    $display("done release");
  endtask
  // Reconfigure pads in standby
  task automatic t_config();
    cfg(11'h7ff, 11'h555, 1'h1, 6'h2a, 4'hf, 1'h0, 1'h1);
    tick(2);
    chk(LANE_O, 32'h2a);
    chk({GPIO_PAD_OE, GPIO_PAD_O}, {11'h7ff, 11'h555});
    chk({PIX_CLK_OE, LINE_VALID_OE, STROBE_OE}, 32'h7);
    chk(PWM_OE, 32'h0);
    chk(FRAME_SYNC_PAD_OE, 32'h1);
    $display("done config");
  endtask
  // Streaming, sync direction flip, back to standby
  task automatic t_stream();
    host.set_stream(1'h1);
    tick(2);
    chk(ACTIVE, 32'h1);
    chk(LANE_O, 32'h15);
    chk(FRAME_SYNC_PAD_O, 32'h1);
    chk({PIX_CLK_O, LINE_VALID_OUT, STROBE_O}, 32'h7);
    cfg(11'h7ff, 11'h555, 1'h0, 6'h2a, 4'hf, 1'h0, 1'h0);
    tick(2);
    chk({FRAME_SYNC_PAD_OE, FRAME_SYNC_IN}, 32'h1);
    chk(GPIO_PAD_O, 32'h6c3);
    host.set_stream(1'h0);
    tick(2);
    chk({ACTIVE, PIX_CLK_O, LINE_VALID_OUT, STROBE_O, LANE_O}, 32'h2a);
    $display("done stream");
  endtask
  // Second shutdown: writes ignored, defaults come back
  task automatic t_reshut();
    host.set_shutdown(1'h0);
    tick(2);
    chk({GPIO_PAD_OE, LANE_OE, PWM_OE, TEST_MODE_OE}, 32'h0);
    cfg(11'h7ff, 11'h7ff, 1'h1, 6'h00, 4'hf, 1'h0, 1'h1);
    host.set_shutdown(1'h1);
    tick(2);
    chk(LANE_O, 32'h3f);
    chk({GPIO_PAD_OE, PWM_OE, FRAME_SYNC_PAD_OE}, 32'h2);
    $display("done reshutdown");
  endtask
  // Test behaviour follows the test input
  task automatic t_test();
    chk(TEST_ACTIVE, 32'h0);
    TEST_MODE_IN = 1'h1;
    tick(2);
    chk(TEST_ACTIVE, 32'h1);
    chk(TEST_MODE_OUT, 32'h1);
    TEST_MODE_IN = 1'h0;
    tick(2);
    chk(TEST_ACTIVE, 32'h0);
    chk(TEST_MODE_OUT, 32'h0);
    $display("done test mode");
  endtask
  // Counts and verdict
  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Main sequence
  initial begin
    {SYS_CLK, RESET_N, TEST_MODE_IN, CFG_WR, CFG_GPIO_MODE} = '0;
    {CFG_GPIO_OE, CFG_GPIO_DO, CFG_LANE_IDLE, CFG_MISC_OE} = '0;
    {CFG_PWM_OE, CFG_SYNC_OUT} = '0;
    {PIX_CLK, LINE_VALID, STROBE_IN, PWM_IN, TEST_OUT_IN} = 5'h1f;
    {VSYNC_IN, SDA_LOW, FRAME_SYNC_PAD_I} = 3'h7;
    VIDEO_DATA = 10'h2c3;
    LANE_DATA = 6'h15;
    tick(8);
    RESET_N = 1'h1;
    t_shutdown();
    t_release();
    t_config();
    t_stream();
    t_reshut();
    t_test();
    end_of_test();
  end
  // Watchdog
  initial begin
    #20000;
    err_count++;
    end_of_test();
  end
endmodule
`default_nettype wire
